// ---- hdl/cpu_bus_cycle_sequencer.v ----
// cycle-by-cycle bus sequencer for extended and indexed-x modes
`timescale 1ns/1ns
module cpu_bus_cycle_sequencer (
  input wire core_clk,
  input wire resetn,
  input wire [15:0] pc_start,
  input wire start,
  input wire [15:0] index_register_x,
  input wire [15:0] stack_ptr,
  input wire [7:0] acc_data,
  input wire [15:0] word_data,
  input wire [7:0] rmw_result,
  input wire [7:0] data_in,
  output reg [15:0] addr_bus,
  output reg rw_line,
  output reg [7:0] data_out,
  output reg data_oe,
  output reg busy,
  output reg done,
  output reg [7:0] opcode_q,
  output reg [15:0] operand_q,
  output reg [15:0] next_pc
);
`include "bus_seq_regs.vh"

  // ****************************************
  // states
  // ****************************************
  localparam ST_IDLE = 4'b0001;
  localparam ST_FETCH = 4'b0010;
  localparam ST_RUN = 4'b0100;
  localparam ST_DONE = 4'b1000;

  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [15:0] pc_ff;
  reg [15:0] nxt_pc;
  reg [7:0] opc_ff;
  reg [7:0] nxt_opc;
  reg prefix_ff;
  reg nxt_prefix;
  reg [7:0] page_ff;
  reg [7:0] nxt_page;
  reg [15:0] ea_ff;
  reg [15:0] nxt_ea;
  reg [2:0] step_ff;
  reg [2:0] nxt_step;
  reg [15:0] oper_ff;
  reg [15:0] nxt_oper;
  reg [15:0] ret_ff;
  reg [15:0] nxt_ret;

  // ****************************************
  // opcode decode
  // ****************************************
  // anything not extended runs the indexed-x step plan
  wire is_ext;
  wire [3:0] seq_class;

  opcode_classifier u_cls (
    .opcode(opc_ff),
    .prefixed(prefix_ff),
    .is_ext(is_ext),
    .is_idx(),
    .seq_class(seq_class)
  );

  // ****************************************
  // page prefix detection
  // ****************************************
  function is_prefix;
    input [7:0] b;
    begin
      is_prefix = (b == `PAGE_PREFIX_18) || (b == `PAGE_PREFIX_1A) || (b == `PAGE_PREFIX_CD);
    end
  endfunction

  // ****************************************
  // per-step bus plan
  // ****************************************
  // step counts from 0 after the opcode byte(s); pc_ff points past them
  reg [15:0] b_addr;
  reg b_rw;
  reg [7:0] b_dout;
  reg b_last;
  wire [15:0] idx_ea;

  // latched into ea_ff at step 0, so later operand reads cannot move it
  assign idx_ea = index_register_x + {8'h00, data_in};

  always @* begin
    b_addr = `DUMMY_ADDR;
    b_rw = `RW_READ;
    b_dout = 8'h00;
    b_last = 1'b0;
    if (is_ext) begin
      case (step_ff)
        3'd0: b_addr = pc_ff;
        3'd1: b_addr = pc_ff + 16'h0001;
        3'd2: begin
          b_addr = ea_ff;
          if (seq_class == `CLS_JUMP) begin
            b_last = 1'b1;
          end
          if (seq_class == `CLS_STORE8) begin
            b_rw = `RW_WRITE;
            b_dout = acc_data;
            b_last = 1'b1;
          end
          if (seq_class == `CLS_STORE16) begin
            b_rw = `RW_WRITE;
            b_dout = word_data[15:8];
          end
          if (seq_class == `CLS_READ8) begin
            b_last = 1'b1;
          end
        end
        3'd3: begin
          case (seq_class)
            `CLS_RMW, `CLS_TEST: b_addr = `DUMMY_ADDR;
            `CLS_CALL: begin
              b_addr = stack_ptr;
              b_rw = `RW_WRITE;
              b_dout = ret_ff[7:0];
            end
            `CLS_STORE16: begin
              b_addr = ea_ff + 16'h0001;
              b_rw = `RW_WRITE;
              b_dout = word_data[7:0];
              b_last = 1'b1;
            end
            `CLS_LOAD16: begin
              b_addr = ea_ff + 16'h0001;
              b_last = 1'b1;
            end
            default: b_addr = ea_ff + 16'h0001;
          endcase
        end
        3'd4: begin
          b_last = 1'b1;
          case (seq_class)
            `CLS_RMW: begin
              b_addr = ea_ff;
              b_rw = `RW_WRITE;
              b_dout = rmw_result;
            end
            `CLS_CALL: begin
              b_addr = stack_ptr - 16'h0001;
              b_rw = `RW_WRITE;
              b_dout = ret_ff[15:8];
            end
            default: b_addr = `DUMMY_ADDR;
          endcase
        end
        default: b_last = 1'b1;
      endcase
    end else begin
      case (step_ff)
        3'd0: b_addr = pc_ff;
        3'd1: begin
          b_addr = `DUMMY_ADDR;
          if (seq_class == `CLS_JUMP) begin
            b_last = 1'b1;
          end
        end
        3'd2: begin
          b_addr = ea_ff;
          case (seq_class)
            `CLS_READ8, `CLS_UNSUP: b_last = 1'b1;
            `CLS_STORE8: begin
              b_rw = `RW_WRITE;
              b_dout = acc_data;
              b_last = 1'b1;
            end
            `CLS_STORE16: begin
              b_rw = `RW_WRITE;
              b_dout = word_data[15:8];
            end
            default: b_rw = `RW_READ;
          endcase
        end
        3'd3: begin
          case (seq_class)
            `CLS_RMW, `CLS_TEST: b_addr = `DUMMY_ADDR;
            `CLS_STORE16: begin
              b_addr = ea_ff + 16'h0001;
              b_rw = `RW_WRITE;
              b_dout = word_data[7:0];
              b_last = 1'b1;
            end
            `CLS_CALL: begin
              b_addr = stack_ptr;
              b_rw = `RW_WRITE;
              b_dout = ret_ff[7:0];
            end
            default: begin
              b_addr = ea_ff + 16'h0001;
              b_last = (seq_class == `CLS_LOAD16);
            end
          endcase
        end
        3'd4: begin
          b_last = 1'b1;
          case (seq_class)
            `CLS_RMW: begin
              b_addr = ea_ff;
              b_rw = `RW_WRITE;
              b_dout = rmw_result;
            end
            `CLS_CALL: begin
              b_addr = stack_ptr - 16'h0001;
              b_rw = `RW_WRITE;
              b_dout = ret_ff[15:8];
            end
            default: b_addr = `DUMMY_ADDR;
          endcase
        end
        default: b_last = 1'b1;
      endcase
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always @* begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_opc = opc_ff;
    nxt_prefix = prefix_ff;
    nxt_page = page_ff;
    nxt_ea = ea_ff;
    nxt_step = step_ff;
    nxt_oper = oper_ff;
    nxt_ret = ret_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_FETCH;
          nxt_pc = pc_start;
          nxt_prefix = 1'b0;
        end
      end
      ST_FETCH: begin
        nxt_pc = pc_ff + 16'h0001;
        nxt_step = 3'd0;
        if (!prefix_ff && is_prefix(data_in)) begin
          nxt_prefix = 1'b1;
          nxt_page = data_in;
        end else begin
          nxt_opc = data_in;
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_step = step_ff + 3'd1;
        if (b_rw == `RW_READ && b_addr != `DUMMY_ADDR) begin
          if (step_ff == 3'd0) begin
            nxt_oper = {8'h00, data_in};
            nxt_ea = is_ext ? {data_in, 8'h00} : idx_ea;
          end else if (step_ff == 3'd1 && is_ext) begin
            nxt_ea = {ea_ff[15:8], data_in};
            nxt_ret = pc_ff + 16'h0002;
          end else begin
            nxt_oper = {oper_ff[7:0], data_in};
          end
        end
        if (step_ff == 3'd1 && !is_ext) begin
          nxt_ret = pc_ff + 16'h0001;
        end
        if (b_last) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // ****************************************
  // sequence control registers
  // ****************************************
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      pc_ff <= 16'h0000;
      prefix_ff <= 1'b0;
      page_ff <= 8'h00;
      step_ff <= 3'd0;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      prefix_ff <= nxt_prefix;
      page_ff <= nxt_page;
      step_ff <= nxt_step;
    end
  end

  // ****************************************
  // opcode and address registers
  // ****************************************
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      opc_ff <= 8'h00;
      ea_ff <= 16'h0000;
    end else begin
      opc_ff <= nxt_opc;
      ea_ff <= nxt_ea;
    end
  end

  // ****************************************
  // operand and return address registers
  // ****************************************
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      oper_ff <= 16'h0000;
      ret_ff <= 16'h0000;
    end else begin
      oper_ff <= nxt_oper;
      ret_ff <= nxt_ret;
    end
  end

  // ****************************************
  // bus outputs
  // ****************************************
  always @* begin
    addr_bus = pc_ff;
    rw_line = `RW_READ;
    data_out = 8'h00;
    data_oe = 1'b0;
    busy = (state_ff != ST_IDLE);
    done = (state_ff == ST_DONE);
    opcode_q = opc_ff;
    operand_q = oper_ff;
    next_pc = pc_ff;
    if (state_ff == ST_IDLE || state_ff == ST_DONE) begin
      addr_bus = `DUMMY_ADDR;
    end else if (state_ff == ST_RUN) begin
      addr_bus = b_addr;
      rw_line = b_rw;
      data_out = b_dout;
      data_oe = (b_rw == `RW_WRITE);
    end
  end
endmodule // cpu_bus_cycle_sequencer

// ---- shared/bus_seq_regs.vh ----
// bus cycle sequencer constants and contract list
// Contract
// - one bus cycle per step, dummies read ffff
// - extended address high then low byte
// - extended read-modify-write six cycles, dummy, write
// - extended operand_test six cycles, no write
// - extended word arithmetic reads high, low, dummy
// - prefixed extended word compare takes seven cycles
// - extended subroutine_call fetches target, reads first opcode
// - subroutine_call pushes return low, then high
// - indexed x: offset fetch, dummy, x plus offset
// - indexed jump_instruction three cycles, no operand
// - indexed eight-bit read four cycles
// - indexed read-modify-write six cycles
// - indexed operand_test six cycles, never writes
// - indexed accumulator store writes in cycle four
// - indexed word load five cycles, high then low
// - indexed load_y_index prefixed six cycles
// - indexed word store starts fetch, offset, dummy
// - indexed word store writes high then low
`ifndef BUS_SEQ_REGS_VH
`define BUS_SEQ_REGS_VH
`define DUMMY_ADDR 16'hFFFF
`define PAGE_PREFIX_18 8'h18
`define PAGE_PREFIX_1A 8'h1A
`define PAGE_PREFIX_CD 8'hCD
`define OPC_EXT_TEST 8'h7D
`define OPC_EXT_CALL 8'hBD
`define OPC_IDX_CALL 8'hAD
`define OPC_IDX_JUMP 8'h6E
`define OPC_IDX_TEST 8'h6D
`define OPC_IDX_LDY 8'hEE
`define OPC_EXT_CMPW 8'hB3
`define OPC_EXT_CMPY 8'hBC
`define RW_READ 1'b1
`define RW_WRITE 1'b0
// sequence classes
`define CLS_READ8 4'h0
`define CLS_RMW 4'h1
`define CLS_TEST 4'h2
`define CLS_WORD_ALU 4'h3
`define CLS_CALL 4'h4
`define CLS_JUMP 4'h5
`define CLS_STORE8 4'h6
`define CLS_LOAD16 4'h7
`define CLS_STORE16 4'h8
`define CLS_UNSUP 4'hF
`endif

// ---- hdl/opcode_classifier.v ----
// opcode to addressing mode and sequence class decoder
`timescale 1ns/1ns
module opcode_classifier (
  input wire [7:0] opcode,
  input wire prefixed,
  output reg is_ext,
  output reg is_idx,
  output reg [3:0] seq_class
);
`include "bus_seq_regs.vh"

  always @* begin
    is_ext = (opcode[7:4] == 4'h7) || (opcode[7:6] == 2'b10 && opcode[5:4] == 2'b11) ||
      (opcode[7:6] == 2'b11 && opcode[5:4] == 2'b11);
    is_idx = (opcode[7:4] == 4'h6) || (opcode[5:4] == 2'b10 && opcode[7] == 1'b1);
    seq_class = `CLS_UNSUP;
    if (opcode[7:4] == 4'h6 || opcode[7:4] == 4'h7) begin
      if (opcode[3:0] == 4'hD) begin
        seq_class = `CLS_TEST;
      end else if (opcode[3:0] == 4'hE) begin
        seq_class = `CLS_JUMP;
      end else begin
        seq_class = `CLS_RMW;
      end
    end else if (opcode[7]) begin
      case (opcode[3:0])
        4'h3, 4'hC: seq_class = `CLS_WORD_ALU;
        4'h7: seq_class = `CLS_STORE8;
        4'hD: seq_class = (opcode[6] || prefixed) ? `CLS_STORE16 : `CLS_CALL;
        4'hE: seq_class = opcode[6] ? `CLS_LOAD16 : (prefixed ? `CLS_LOAD16 : `CLS_LOAD16);
        4'hF: seq_class = `CLS_STORE16;
        default: seq_class = `CLS_READ8;
      endcase
      if (opcode[3:0] == 4'hC && opcode[6]) begin
        seq_class = `CLS_LOAD16;
      end
    end
  end
endmodule // opcode_classifier

// ---- dv/cpu_bus_cycle_sequencer_assertions.sv ----
// concurrent checks on the sequencer bus ports
`timescale 1ns/1ns
module cpu_bus_cycle_sequencer_assertions (
  input wire core_clk,
  input wire resetn,
  input wire [15:0] pc_start,
  input wire start,
  input wire [15:0] stack_ptr,
  input wire [15:0] word_data,
  input wire [7:0] rmw_result,
  input wire [15:0] addr_bus,
  input wire rw_line,
  input wire [7:0] data_out,
  input wire data_oe,
  input wire busy,
  input wire done
);
  // ****
  // checks
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_START_FETCH:
  assert property (!busy && start |=> busy && rw_line && addr_bus == $past(pc_start))
    else $error("first fetch not at start address");
  AST_IDLE_QUIET:
  assert property (!busy && !start |=> !busy) else $error("busy without start");
  AST_DONE_PULSE:
  assert property (done |=> !done) else $error("done longer than one cycle");
  AST_BUSY_SPAN:
  assert property ($rose(busy) |-> busy [*4] ##[1:5] !busy)
    else $error("instruction length out of range");
  AST_DUMMY_READ:
  assert property (busy && addr_bus == 16'hFFFF |-> rw_line) else $error("write to dummy address");
  AST_OE_WRITE:
  assert property (busy |-> data_oe == !rw_line) else $error("data enable not tied to write");
  AST_FETCH_READS:
  assert property ($rose(busy) |-> rw_line ##1 rw_line) else $error("write during fetch");
  AST_RMW_SAME_ADDR:
  assert property (busy && !rw_line && data_out == rmw_result
    |-> addr_bus == $past(addr_bus, 2) && $past(rw_line, 2)) else $error("result write misplaced");
  AST_PUSH_ORDER:
  assert property (busy && !rw_line && addr_bus == stack_ptr
    |=> !rw_line && addr_bus == stack_ptr - 16'h0001) else $error("return push order wrong");
  AST_STORE_PAIR:
  assert property (busy && !rw_line && addr_bus != stack_ptr && data_out == word_data[15:8]
    |=> !rw_line && addr_bus == $past(addr_bus) + 16'h0001 && data_out == word_data[7:0])
    else $error("word store low byte wrong");
endmodule // cpu_bus_cycle_sequencer_assertions

bind cpu_bus_cycle_sequencer cpu_bus_cycle_sequencer_assertions chk_i (.core_clk, .resetn,
  .pc_start, .start, .stack_ptr, .word_data, .rmw_result, .addr_bus, .rw_line, .data_out,
  .data_oe, .busy, .done);

// ---- dv/bus_memory_model.sv ----
// byte memory answering the sequencer bus cycles
`timescale 1ns/1ns
module bus_memory_model (
  input wire core_clk,
  input wire [15:0] addr_bus,
  input wire rw_line,
  input wire [7:0] data_out,
  input wire data_oe,
  output wire [7:0] data_in
);
  logic [7:0] mem [0:65535];
  initial foreach (mem[i]) mem[i] = i[7:0];
  // no stale value on the read line during writes
  assign data_in = rw_line ? mem[addr_bus] : ~data_out;
  always @(posedge core_clk) begin
    if (!rw_line && data_oe) begin
      mem[addr_bus] <= data_out;
    end
  end
endmodule // bus_memory_model

// ---- dv/tb_cpu_bus_cycle_sequencer.sv ----
// self-checking bench for the bus cycle sequencer
`timescale 1ns/1ns
`include "bus_seq_regs.vh"
module tb_cpu_bus_cycle_sequencer;
  typedef struct {logic [7:0] pre; logic [7:0] opc; logic ext; int n; logic [27:0] seq;} row_t;
  logic core_clk, resetn, start, rw_line, data_oe, busy, done;
  logic [15:0] pc_start, index_register_x, stack_ptr, word_data, addr_bus, ea;
  logic [15:0] operand_q, next_pc;
  logic [7:0] acc_data, rmw_result, data_in, data_out, opcode_q;
  int err_count, compares;
  row_t rows [13];
  cpu_bus_cycle_sequencer DUT (.core_clk, .resetn, .pc_start, .start, .index_register_x,
    .stack_ptr, .acc_data, .word_data, .rmw_result, .data_in, .addr_bus, .rw_line,
    .data_out, .data_oe, .busy, .done, .opcode_q, .operand_q, .next_pc);
  bus_memory_model mem_i (.core_clk, .addr_bus, .rw_line, .data_out, .data_oe, .data_in);
  initial begin
    core_clk = 0;
    forever #10 core_clk = ~core_clk;
  end
  // ****
  // helpers
  // ****
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // cycle code: 0-3 pc+n, 4 dummy, 5/6 ea, bit 3 set marks a write
  function logic [31:0] exp_cyc(input logic [3:0] c);
    logic [15:0] a;
    logic [7:0] d;
    d = 8'h00;
    case (c)
      4'h4: a = 16'hFFFF;
      4'h5, 4'h8, 4'hA, 4'hE: a = ea;
      4'h6, 4'h9: a = ea + 16'h0001;
      4'hC: a = stack_ptr;
      4'hD: a = stack_ptr - 16'h0001;
      default: a = 16'h1000 + {12'h000, c};
    endcase
    case (c)
      4'h8: d = word_data[15:8];
      4'h9: d = word_data[7:0];
      4'hA: d = rmw_result;
      4'hC: d = 8'h03;
      4'hD: d = 8'h10;
      4'hE: d = acc_data;
      default: d = 8'h00;
    endcase
    return {6'h00, c[3], ~c[3], a, d};
  endfunction
  task run(input row_t r, input logic poke);
    logic [15:0] b;
    b = r.pre != 8'h00 ? 16'h1001 : 16'h1000;
    mem_i.mem[16'h1000] = r.pre != 8'h00 ? r.pre : r.opc;
    mem_i.mem[b] = r.opc;
    mem_i.mem[b + 16'h0001] = 8'h40;
    mem_i.mem[b + 16'h0002] = 8'h50;
    ea = r.ext ? 16'h4050 : 16'h2040;
    @(posedge core_clk);
    #1 start = 1;
    @(posedge core_clk);
    for (int i = 0; i < r.n; i++) begin
      if (i > 0) @(posedge core_clk);
      #1 start = poke && i == 0;
      check({6'h00, data_oe, rw_line, addr_bus, rw_line ? 8'h00 : data_out},
        exp_cyc(r.seq[27 - 4 * i -: 4]));
    end
    @(posedge core_clk);
    #1 check({31'h0, done}, 32'h1);
    check({24'h0, opcode_q}, {24'h0, r.opc});
    check({16'h0, next_pc}, {16'h0, b + 16'h0001});
    @(posedge core_clk);
    #1 check({30'h0, done, busy}, 32'h0);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    resetn = 0;
    start = 0;
    pc_start = 16'h1000;
    index_register_x = 16'h2000;
    stack_ptr = 16'h3000;
    acc_data = 8'hC3;
    word_data = 16'hA55A;
    rmw_result = 8'h3C;
    err_count = 0;
    compares = 0;
    ea = 16'h0000;
    rows = '{
      '{8'h00, 8'h7C, 1'b1, 6, 28'h012_54A0},
      '{8'h00, `OPC_EXT_TEST, 1'b1, 6, 28'h012_5440},
      '{8'h00, `OPC_EXT_CMPW, 1'b1, 6, 28'h012_5640},
      '{`PAGE_PREFIX_1A, `OPC_EXT_CMPW, 1'b1, 7, 28'h012_3564},
      '{8'h00, `OPC_EXT_CALL, 1'b1, 6, 28'h012_5CD0},
      '{8'h00, `OPC_IDX_JUMP, 1'b0, 3, 28'h014_0000},
      '{8'h00, 8'hA6, 1'b0, 4, 28'h014_5000},
      '{8'h00, 8'h6C, 1'b0, 6, 28'h014_54A0},
      '{8'h00, `OPC_IDX_TEST, 1'b0, 6, 28'h014_5440},
      '{8'h00, 8'hA7, 1'b0, 4, 28'h014_E000},
      '{8'h00, 8'hEC, 1'b0, 5, 28'h014_5600},
      '{`PAGE_PREFIX_1A, `OPC_IDX_LDY, 1'b0, 6, 28'h012_4560},
      '{8'h00, 8'hED, 1'b0, 5, 28'h014_8900}};
    repeat (20) @(posedge core_clk);
    #1 resetn = 1;
    foreach (rows[k]) begin
      run(rows[k], k == 5);
      $display("row %0d finished", k);
    end
    // load back the word that the last store left behind
    run(rows[10], 1'b0);
    check({16'h0, operand_q}, {16'h0, word_data});
    $display("load back test finished");
    // reset in mid-instruction, start held while busy
    @(posedge core_clk);
    #1 start = 1;
    repeat (3) @(posedge core_clk);
    #1 start = 0;
    resetn = 0;
    #2 check({13'h0000, data_oe, rw_line, busy, addr_bus}, {13'h0000, 3'b010, 16'hFFFF});
    repeat (2) @(posedge core_clk);
    #1 resetn = 1;
    run(rows[0], 1'b0);
    $display("reset test finished");
    finish_test;
  end
  // whole run needs a few microseconds
  initial begin
    #100000;
    err_count++;
    finish_test;
  end
endmodule // tb_cpu_bus_cycle_sequencer
